/* File: rtl/tws_slave.sv */
// Two-wire serial slave front end with status latches and control-section write guard
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps

module tws_slave #(
  parameter int NV_CYCLES = tws_pkg::NV_WRITE_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [1:0]  htrans,
  input  wire logic [31:0] haddr,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe
);

  localparam int NVW = $clog2(NV_CYCLES + 1);

  logic [7:0]              array_mem [tws_pkg::ARRAY_DEPTH];
  logic [7:0]              ctrl_mem  [tws_pkg::CTRL_DEPTH];

  logic                    scl_s1_reg;
  logic                    scl_s2_reg;
  logic                    scl_s3_reg;
  logic                    sda_s1_reg;
  logic                    sda_s2_reg;
  logic                    sda_s3_reg;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    start_det;
  logic                    stop_det;

  tws_pkg::tws_state_type  state_reg;
  tws_pkg::tws_kind_type   kind_reg;
  logic [7:0]              shift_reg;
  logic [3:0]              bitcnt_reg;
  logic                    ack_ok_reg;
  logic                    is_ctrl_reg;
  logic                    rnw_reg;
  logic [7:0]              addr_hi_reg;
  logic [15:0]             addr_reg;
  logic [7:0]              data_cnt_reg;
  logic                    wrote_reg;
  logic                    wrote_ctrl_reg;
  logic                    wel_reg;
  logic                    register_write_latch_reg;
  logic                    busy_reg;
  logic [NVW-1:0]          nv_cnt_reg;
  logic                    nv_start_reg;
  logic                    nv_ctrl_reg;
  logic                    wr_arr_reg;
  logic                    wr_ctrl_reg;
  logic [15:0]             wr_addr_reg;
  logic [7:0]              wr_data_reg;
  logic                    sda_oe_reg;
  logic                    sda_out_reg;

  logic [31:0]             ctrl_reg;
  logic                    dph_wr_reg;
  logic [7:0]              dph_addr_reg;
  logic [31:0]             hrdata_reg;
  logic                    hreadyout_reg;
  logic                    hresp_reg;

  logic                    id_match;
  logic                    sr_sel;
  logic                    ctrl_defined;
  logic [7:0]              rd_byte;
  logic [7:0]              sr_value;
  logic [15:0]             addr_wrap;
  logic                    ahb_take;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus condition detection

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
    end
    else
    begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
    end
  end

  assign scl_rise  = scl_s2_reg & ~scl_s3_reg;
  assign scl_fall  = ~scl_s2_reg & scl_s3_reg;
  assign start_det = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
  assign stop_det  = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  assign id_match = (shift_reg[7:1] == tws_pkg::ARRAY_ID) ||
                    (shift_reg[7:1] == tws_pkg::CTRL_ID);
  assign sr_sel       = is_ctrl_reg && (addr_reg == tws_pkg::SR_ADDR);
  assign ctrl_defined = (addr_reg[15:6] == 10'h000) &&
                        (addr_reg[5:0] <= tws_pkg::CTRL_LAST_DEF);

  always_comb
  begin
    sr_value = 8'h00;
    sr_value[tws_pkg::SR_REGISTER_WRITE_LATCH_BIT] = register_write_latch_reg;
    sr_value[tws_pkg::SR_WEL_BIT]  = wel_reg;
  end

  always_comb
  begin
    if (sr_sel)
      rd_byte = sr_value;
    else if (is_ctrl_reg)
      rd_byte = ctrl_defined ? ctrl_mem[addr_reg[5:0]] : 8'h00;
    else
      rd_byte = array_mem[addr_reg[8:0]];
  end

  // Write address rolls over within its page
  always_comb
  begin
    addr_wrap = addr_reg;
    if (is_ctrl_reg)
      addr_wrap[tws_pkg::CTRL_PAGE_W-1:0] = addr_reg[tws_pkg::CTRL_PAGE_W-1:0] + 3'h1;
    else
      addr_wrap[tws_pkg::ARRAY_PAGE_W-1:0] = addr_reg[tws_pkg::ARRAY_PAGE_W-1:0] + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus protocol state machine

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg      <= tws_pkg::ST_IDLE;
      kind_reg       <= tws_pkg::K_SLAVE;
      shift_reg      <= 8'h00;
      bitcnt_reg     <= 4'h0;
      ack_ok_reg     <= 1'b0;
      is_ctrl_reg    <= 1'b0;
      rnw_reg        <= 1'b0;
      addr_hi_reg    <= 8'h00;
      addr_reg       <= 16'h0000;
      data_cnt_reg   <= 8'h00;
      wrote_reg      <= 1'b0;
      wrote_ctrl_reg <= 1'b0;
      wel_reg        <= 1'b0;
      register_write_latch_reg       <= 1'b0;
      nv_start_reg   <= 1'b0;
      nv_ctrl_reg    <= 1'b0;
      wr_arr_reg     <= 1'b0;
      wr_ctrl_reg    <= 1'b0;
      wr_addr_reg    <= 16'h0000;
      wr_data_reg    <= 8'h00;
      sda_oe_reg     <= 1'b0;
    end
    else
    begin
      nv_start_reg <= 1'b0;
      wr_arr_reg   <= 1'b0;
      wr_ctrl_reg  <= 1'b0;
      // Completion of a control-section cycle drops the register latch
      if (busy_reg && nv_cnt_reg == NVW'(1) && nv_ctrl_reg)
        register_write_latch_reg <= 1'b0;
      if (busy_reg || !ctrl_reg[tws_pkg::CTRL_EN_BIT])
      begin
        state_reg  <= tws_pkg::ST_IDLE;
        sda_oe_reg <= 1'b0;
      end
      else if (start_det)
      begin
        state_reg  <= tws_pkg::ST_RX;
        kind_reg   <= tws_pkg::K_SLAVE;
        bitcnt_reg <= 4'h0;
        wrote_reg  <= 1'b0;
        sda_oe_reg <= 1'b0;
      end
      else if (stop_det)
      begin
        state_reg  <= tws_pkg::ST_IDLE;
        sda_oe_reg <= 1'b0;
        // Completed write launches programming
        // The stop's own clock rise has already shifted one bit in
        if (wrote_reg && state_reg == tws_pkg::ST_RX && bitcnt_reg <= 4'h1)
        begin
          nv_start_reg <= 1'b1;
          nv_ctrl_reg  <= wrote_ctrl_reg;
        end
        wrote_reg <= 1'b0;
      end
      else
      begin
        case (state_reg)
          tws_pkg::ST_IDLE:
          begin
            sda_oe_reg <= 1'b0;
          end
          tws_pkg::ST_RX:
          begin
            if (scl_rise && bitcnt_reg != 4'h8)
            begin
              shift_reg  <= {shift_reg[6:0], sda_s2_reg};
              bitcnt_reg <= bitcnt_reg + 4'h1;
            end
            else if (scl_fall && bitcnt_reg == 4'h8)
            begin
              bitcnt_reg <= 4'h0;
              ack_ok_reg <= 1'b1;
              case (kind_reg)
                tws_pkg::K_SLAVE:
                begin
                  // Acknowledge only a matching slave byte
                  ack_ok_reg <= id_match;
                  is_ctrl_reg <= (shift_reg[7:1] == tws_pkg::CTRL_ID);
                  rnw_reg <= shift_reg[0];
                  // The address high byte comes next for writes; a read goes from the ack to ST_TX
                  kind_reg <= tws_pkg::K_ADDR_HI;
                end
                tws_pkg::K_ADDR_HI:
                begin
                  addr_hi_reg <= shift_reg;
                  kind_reg    <= tws_pkg::K_ADDR_LO;
                end
                tws_pkg::K_ADDR_LO:
                begin
                  addr_reg     <= {addr_hi_reg, shift_reg};
                  data_cnt_reg <= 8'h00;
                  kind_reg     <= tws_pkg::K_DATA;
                end
                default:
                begin
                  if (data_cnt_reg != 8'hff)
                    data_cnt_reg <= data_cnt_reg + 8'h01;
                  if (sr_sel)
                  begin
                    ack_ok_reg <= (data_cnt_reg == 8'h00);
                    if (data_cnt_reg == 8'h00)
                    begin
                      if (shift_reg == tws_pkg::SR_CMD_CLEAR)
                      begin
                        wel_reg  <= 1'b0;
                        register_write_latch_reg <= 1'b0;
                      end
                      else if (shift_reg == tws_pkg::SR_CMD_WEL)
                        wel_reg <= 1'b1;
                      else if (shift_reg == tws_pkg::SR_CMD_BOTH && wel_reg)
                      begin
                        wel_reg  <= 1'b1;
                        register_write_latch_reg <= 1'b1;
                      end
                    end
                  end
                  // Data refused while enable latch clear
                  else if (!wel_reg)
                    ack_ok_reg <= 1'b0;
                  else
                  begin
                    addr_reg    <= addr_wrap;
                    wr_addr_reg <= addr_reg;
                    wr_data_reg <= shift_reg;
                    if (!is_ctrl_reg)
                    begin
                      wr_arr_reg <= 1'b1;
                      wrote_reg  <= 1'b1;
                    end
                    else if (register_write_latch_reg && ctrl_defined)
                    begin
                      // One to eight control bytes stored
                      wr_ctrl_reg    <= 1'b1;
                      wrote_reg      <= 1'b1;
                      wrote_ctrl_reg <= 1'b1;
                    end
                  end
                end
              endcase
              state_reg <= tws_pkg::ST_ACK;
            end
          end
          tws_pkg::ST_ACK:
          begin
            // Ack is driven one pulse late so the clock is already low
            if (bitcnt_reg == 4'h0)
            begin
              sda_oe_reg <= ack_ok_reg;
              bitcnt_reg <= 4'h1;
              if (kind_reg == tws_pkg::K_ADDR_HI && ack_ok_reg)
                wrote_ctrl_reg <= 1'b0;
            end
            else if (scl_fall)
            begin
              bitcnt_reg <= 4'h0;
              sda_oe_reg <= 1'b0;
              if (!ack_ok_reg)
                state_reg <= tws_pkg::ST_IDLE;
              else if (kind_reg == tws_pkg::K_ADDR_HI && rnw_reg)
              begin
                // First read byte follows the ack
                shift_reg  <= rd_byte;
                sda_oe_reg <= ~rd_byte[7];
                addr_reg   <= addr_reg + 16'h0001;
                bitcnt_reg <= 4'h1;
                state_reg  <= tws_pkg::ST_TX;
              end
              else
                state_reg <= tws_pkg::ST_RX;
            end
          end
          tws_pkg::ST_TX:
          begin
            if (scl_fall)
            begin
              // Output changes on the falling clock
              if (bitcnt_reg == 4'h8)
              begin
                sda_oe_reg <= 1'b0;
                state_reg  <= tws_pkg::ST_TXACK;
              end
              else
              begin
                sda_oe_reg <= ~shift_reg[6];
                shift_reg  <= {shift_reg[6:0], 1'b0};
                bitcnt_reg <= bitcnt_reg + 4'h1;
              end
            end
          end
          tws_pkg::ST_TXACK:
          begin
            if (scl_rise)
              ack_ok_reg <= ~sda_s2_reg;
            else if (scl_fall)
            begin
              // Reads only move the address counter
              // Continue on ack, stop on nack
              if (ack_ok_reg)
              begin
                shift_reg  <= rd_byte;
                sda_oe_reg <= ~rd_byte[7];
                addr_reg   <= addr_reg + 16'h0001;
                bitcnt_reg <= 4'h1;
                state_reg  <= tws_pkg::ST_TX;
              end
              else
                // Wait for the master's stop or start
                state_reg <= tws_pkg::ST_IDLE;
            end
          end
          default:
          begin
            state_reg <= tws_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Open-drain: the low level is the only value ever driven
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sda_out_reg <= 1'b0;
    else
      sda_out_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Storage; cells are modelled as plain memory written per byte

  always_ff @(posedge hclk)
  begin
    if (wr_arr_reg)
      array_mem[wr_addr_reg[8:0]] <= wr_data_reg;
    if (wr_ctrl_reg)
      ctrl_mem[wr_addr_reg[5:0]] <= wr_data_reg;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Nonvolatile programming timer

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy_reg   <= 1'b0;
      nv_cnt_reg <= '0;
    end
    // Cycle bounded by the programming time
    else if (nv_start_reg)
    begin
      busy_reg   <= 1'b1;
      nv_cnt_reg <= NVW'(NV_CYCLES);
    end
    else if (busy_reg)
    begin
      nv_cnt_reg <= nv_cnt_reg - NVW'(1);
      if (nv_cnt_reg == NVW'(1))
        busy_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite register slave, zero wait states

  assign ahb_take = hsel && hready && (htrans == tws_pkg::HTRANS_NONSEQ);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_wr_reg    <= 1'b0;
      dph_addr_reg  <= 8'h00;
      hrdata_reg    <= 32'h0000_0000;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end
    else
    begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
      dph_wr_reg    <= ahb_take && hwrite;
      dph_addr_reg  <= haddr[7:0];
      hrdata_reg    <= 32'h0000_0000;
      if (ahb_take && !hwrite && haddr[31:8] == 24'h000000)
      begin
        case (haddr[7:0])
          tws_pkg::REG_CTRL:
            hrdata_reg <= ctrl_reg;
          tws_pkg::REG_STATUS:
          begin
            hrdata_reg[tws_pkg::ST_WEL_BIT]    <= wel_reg;
            hrdata_reg[tws_pkg::ST_REGISTER_WRITE_LATCH_BIT]   <= register_write_latch_reg;
            hrdata_reg[tws_pkg::ST_BUSY_BIT]   <= busy_reg;
            hrdata_reg[tws_pkg::ST_ACTIVE_BIT] <= (state_reg != tws_pkg::ST_IDLE);
          end
          tws_pkg::REG_ADDR:
            hrdata_reg <= {16'h0000, addr_reg};
          default:
            hrdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_reg <= tws_pkg::CTRL_RESET;
    else if (dph_wr_reg && dph_addr_reg == tws_pkg::REG_CTRL)
      ctrl_reg <= {31'h0000_0000, hwdata[tws_pkg::CTRL_EN_BIT]};
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;
  assign sda_oe    = sda_oe_reg;
  assign sda_out   = sda_out_reg;

endmodule

/* File: pkg/tws_pkg.sv */
// Constants and types shared by the two-wire slave with control-section write guard
package tws_pkg;

  // Slave byte identifiers (upper seven bits)
  localparam logic [6:0] ARRAY_ID       = 7'h57;
  localparam logic [6:0] CTRL_ID        = 7'h6f;

  // Control-section and array layout
  localparam logic [15:0] SR_ADDR       = 16'h003f;
  localparam logic [5:0]  CTRL_LAST_DEF = 6'h37;
  localparam int          CTRL_DEPTH    = 64;
  localparam int          ARRAY_DEPTH   = 512;

  // Status register bit positions and latch command bytes
  localparam int          SR_REGISTER_WRITE_LATCH_BIT   = 2;
  localparam int          SR_WEL_BIT    = 1;
  localparam logic [7:0]  SR_CMD_CLEAR  = 8'h00;
  localparam logic [7:0]  SR_CMD_WEL    = 8'h02;
  localparam logic [7:0]  SR_CMD_BOTH   = 8'h06;

  // Page wrap widths (address bits that roll over)
  localparam int          CTRL_PAGE_W   = 3;
  localparam int          ARRAY_PAGE_W  = 6;

  // Timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          NV_WRITE_NS   = 10_000_000;
  localparam int          NV_WRITE_CYC  = NV_WRITE_NS / CLK_PERIOD_NS;

  // Host register map (byte addresses)
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_ADDR      = 8'h08;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          ST_WEL_BIT    = 0;
  localparam int          ST_REGISTER_WRITE_LATCH_BIT   = 1;
  localparam int          ST_BUSY_BIT   = 2;
  localparam int          ST_ACTIVE_BIT = 3;

  // AHB transfer type
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK
  } tws_state_type;

  typedef enum logic [1:0] {
    K_SLAVE,
    K_ADDR_HI,
    K_ADDR_LO,
    K_DATA
  } tws_kind_type;

endpackage

/* File: bench/tws_slave_monitor.sv */
// Port checker for the two-wire slave
`timescale 1ns/1ps
module tws_slave_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] haddr,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic rd;
  assign rd = hsel && hready && htrans == tws_pkg::HTRANS_NONSEQ && !hwrite;
  ////////////////////////////////////////
  ready_high_a: assert property (hreadyout)
    else $error("hreadyout low");
  open_drain_a: assert property (!sda_out)
    else $error("sda_out high");
  okay_resp_a: assert property (!hresp)
    else $error("hresp not okay");
  sda_hold_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("sda moved while scl high");
  latch_order_a: assert property (rd && haddr == 32'h4 |=> hrdata[1:0] != 2'b10)
    else $error("register latch without enable");
  status_bits_a: assert property (rd && haddr == 32'h4 |=> hrdata[31:4] == 28'h0)
    else $error("status spare bits set");
  addr_bits_a: assert property (rd && haddr == 32'h8 |=> hrdata[31:16] == 16'h0)
    else $error("address high bits set");
  unmapped_a: assert property (rd && haddr > 32'h8 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  idle_data_a: assert property (!rd |=> hrdata == 32'h0)
    else $error("read data without read");
endmodule
bind tws_slave tws_slave_monitor i_tws_slave_monitor (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .haddr(haddr),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe));

/* File: bench/tws_i2c_master.sv */
// Two-wire bus master model driving the slave's serial pins
`timescale 1ns/1ps
module tws_i2c_master (
  output logic      scl = 1'b1,
  output logic      sda_low = 1'b0,
  input  wire logic sda
);
  localparam realtime Q = 31.25;
  task automatic stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask
  task automatic start();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // ack to go on, nack to end
  task automatic rbyte(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, v[i]);
    bit_io(last, r);
  endtask
endmodule

/* File: bench/tws_slave_tb.sv */
// Self-checking bench for the two-wire slave
`timescale 1ns/1ps
module tws_slave_tb;
  localparam int NV = 400;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic        hreadyout;
  logic        sda_oe;
  logic        scl;
  logic        m_low;
  // Pull-up: the line is high unless someone pulls it
  wire         sda = !(m_low || sda_oe);
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic        write_enable_latch = 1'b0, register_write_latch = 1'b0, busy = 1'b0;
  logic [7:0]  ak;
  logic [7:0]  d[$];
  always #5 hclk = ~hclk;
  tws_slave #(.NV_CYCLES(NV)) i_tws_slave (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .htrans(htrans), .haddr(haddr),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe));
  tws_i2c_master i_tws_i2c_master (.scl(scl), .sda_low(m_low), .sda(sda));
  ////////////////////////////////////////
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      test_done();
    end
  end
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge hclk);
    htrans <= tws_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= v;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic cst();
    ahb(1'b0, tws_pkg::REG_STATUS, 32'h0);
    chk(r, {29'h0, busy, register_write_latch, write_enable_latch});
  endtask
  task automatic fr(input logic [7:0] q[$], input logic fin, input logic [7:0] exp);
    logic a;
    ak = 8'h0;
    i_tws_i2c_master.start();
    foreach (q[i])
    begin
      i_tws_i2c_master.wbyte(q[i], a);
      ak[i] = a;
    end
    if (fin)
      i_tws_i2c_master.stop();
    #200;
    chk({24'h0, ak}, {24'h0, exp});
  endtask
  task automatic rread(input logic [7:0] lo, input logic [7:0] q[$]);
    logic [7:0] v;
    fr('{8'hde, 8'h00, lo}, 1'b0, 8'h07);
    i_tws_i2c_master.start();
    i_tws_i2c_master.wbyte(8'hdf, v[0]);
    chk({31'h0, v[0]}, 32'h0000_0001);
    foreach (q[i])
    begin
      i_tws_i2c_master.rbyte(i == q.size() - 1, v);
      chk({24'h0, v}, {24'h0, q[i]});
    end
    i_tws_i2c_master.stop();
    #200;
  endtask
  ////////////////////////////////////////
  initial
  begin
    void'($urandom(19009));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    cst();
    ahb(1'b0, tws_pkg::REG_ADDR, 32'h0);
    chk(r, 32'h0);
    ahb(1'b0, 8'h40, 32'h0);
    chk(r, 32'h0);
    $display("test reset done");
    // Write direction only, so a match never starts a read
    for (int k = 0; k < 6; k++)
    begin
      d = '{8'($urandom) & 8'hfe};
      fr(d, 1'b1, {7'h0, d[0][7:1] inside {tws_pkg::ARRAY_ID, tws_pkg::CTRL_ID}});
    end
    fr('{8'hae}, 1'b1, 8'h01);
    ahb(1'b1, tws_pkg::REG_CTRL, 32'h0);
    fr('{8'hae}, 1'b1, 8'h00);
    ahb(1'b1, tws_pkg::REG_CTRL, 32'h1);
    fr('{8'hae, 8'h00, 8'h10, 8'h55}, 1'b1, 8'h07);
    $display("test decode done");
    fr('{8'hde, 8'h00, 8'h3f, tws_pkg::SR_CMD_WEL}, 1'b1, 8'h0f);
    write_enable_latch = 1'b1;
    cst();
    fr('{8'hde, 8'h00, 8'h3f, tws_pkg::SR_CMD_BOTH, 8'h00}, 1'b1, 8'h0f);
    register_write_latch = 1'b1;
    cst();
    i_tws_i2c_master.start();
    // Status read: array cells hold no known value yet
    i_tws_i2c_master.wbyte(8'hdf, ak[0]);
    i_tws_i2c_master.rbyte(1'b1, ak);
    chk({24'h0, ak}, {29'h0, register_write_latch, write_enable_latch, 1'b0});
    i_tws_i2c_master.stop();
    #200;
    cst();
    $display("test latches done");
    d = '{8'hde, 8'h00, 8'h06, 8'($urandom), 8'($urandom), 8'($urandom)};
    fr(d, 1'b1, 8'h3f);
    busy = 1'b1;
    cst();
    fr('{8'hae}, 1'b1, 8'h00);
    repeat (NV) @(posedge hclk);
    busy = 1'b0;
    register_write_latch = 1'b0;
    cst();
    rread(8'h06, '{d[3], d[4]});
    rread(8'h00, '{d[5]});
    $display("test control write done");
    fr('{8'hde, 8'h00, 8'h3f, tws_pkg::SR_CMD_BOTH}, 1'b1, 8'h0f);
    register_write_latch = 1'b1;
    fr('{8'hde, 8'h00, 8'h38, 8'haa}, 1'b1, 8'h0f);
    cst();
    fr('{8'hde, 8'h00, 8'h01}, 1'b0, 8'h07);
    repeat (3) i_tws_i2c_master.bit_io(1'b1, ak[0]);
    i_tws_i2c_master.start();
    i_tws_i2c_master.stop();
    #200;
    cst();
    fr('{8'hde, 8'h00, 8'h3f, tws_pkg::SR_CMD_CLEAR}, 1'b1, 8'h0f);
    write_enable_latch = 1'b0;
    register_write_latch = 1'b0;
    cst();
    $display("test abort and clear done");
    test_done();
  end
endmodule
